// ==== rtl/dsw_port.sv ====
`timescale 1ns/1ps
module dsw_port #(
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clock_in,
  input wire logic nrst_in,
  input dsw_pkg::dsw_pins_type pins_in,
  input wire logic dac_ready_in,
  output dsw_pkg::dsw_dac_type dac_out,
  output logic frame_active_out
);
  import dsw_pkg::*;

  dsw_top_state_type q;
  dsw_top_state_type d;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [DSW_WORD_BITS-1:0] fifo_out_data;
  logic sclk_fall;
  logic frame_fall;
  dsw_word_type head;

  // ==========================================================
  // edge detect on settled stages only; stage one feeds stage two alone
  assign sclk_fall = q.s3.sclk & ~q.s2.sclk;
  assign frame_fall = q.s3.frame_n & ~q.s2.frame_n;
  assign head = dsw_word_type'(fifo_out_data);

  // ==========================================================
  // frame sequencer, push and drain
  always_comb begin
    d = q;
    d.s1 = pins_in;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.dac.update = 1'b0;
    case (q.fsm)
      DSW_IDLE: begin
        d.cnt = DSW_CNT_RST;
        if (frame_fall) begin
          d.fsm = DSW_SHIFT;
        end
      end
      DSW_SHIFT: begin
        if (q.s2.frame_n) begin
          d.fsm = DSW_IDLE;
          d.cnt = DSW_CNT_RST;
        end else if (sclk_fall) begin
          d.shift = {q.shift[DSW_WORD_BITS-2:0], q.s2.data};
          d.cnt = q.cnt + 5'h01;
          if (q.cnt == DSW_CNT_LAST) begin
            d.fsm = DSW_DONE;
          end
        end
      end
      DSW_DONE: begin
        // further clocks ignored until frame select goes high again
        if (q.s2.frame_n) begin
          d.fsm = DSW_IDLE;
        end
      end
      default: begin
        d.fsm = DSW_IDLE;
      end
    endcase
    // a held word leaves as soon as the buffer has room
    if (q.pend && fifo_in_ready) begin
      d.pend = 1'b0;
    end
    // completed word; a second one while still holding is lost and flagged
    if (q.fsm == DSW_SHIFT && d.fsm == DSW_DONE) begin
      if (d.pend) begin
        d.dac.overrun = 1'b1;
      end else begin
        d.pend = 1'b1;
        d.pend_word = dsw_word_type'(d.shift);
      end
    end
    // apply mode and code; spare bits dropped
    if (fifo_out_valid && dac_ready_in) begin
      d.dac.mode = head.mode;
      d.dac.code = head.code;
      d.dac.update = 1'b1;
    end
    d.frame_active = (d.fsm == DSW_SHIFT);
  end

  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      q <= DSW_TOP_RST;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // word buffer between the serial side and the converter
  dsw_fifo #(
    .WIDTH(DSW_WORD_BITS),
    .DEPTH(FIFO_DEPTH)
  ) dsw_fifo_inst (
    .clock_in(clock_in),
    .nrst_in(nrst_in),
    .in_valid_in(q.pend),
    .in_ready_out(fifo_in_ready),
    .in_data_in(q.pend_word),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(dac_ready_in),
    .out_data_out(fifo_out_data)
  );

  // outputs straight from flops
  assign dac_out = q.dac;
  assign frame_active_out = q.frame_active;

endmodule

// ==== shared/dsw_pkg.sv ====
// How it works
// - frame select is active low; shifting is enabled only while it is low
// - one data bit is captured on each of the first sixteen falling serial clock edges in a frame
// - the input shift register is exactly sixteen bits wide
// - the word is applied once the sixteenth falling edge has completed
// - frame select rising before sixteen edges aborts; DAC code and mode stay
// - top two bits pick mode, next twelve are code, last two ignored
package dsw_pkg;

  // ==========================================================
  // word layout
  localparam int DSW_WORD_BITS = 16;
  localparam int DSW_CODE_BITS = 12;
  localparam int DSW_MODE_BITS = 2;
  localparam int DSW_FIFO_DEPTH = 8;
  localparam logic [4:0] DSW_CNT_RST = 5'h00;
  localparam logic [4:0] DSW_CNT_LAST = 5'h0F;
  localparam logic [1:0] DSW_MODE_RST = 2'h0;
  localparam logic [11:0] DSW_CODE_RST = 12'h000;

  // ==========================================================
  // timing
  localparam int DSW_CLK_MHZ = 200;
  localparam int DSW_SCLK_MAX_MHZ = 30;
  localparam int DSW_SYNC_HIGH_MIN_NS = 33;
  localparam int DSW_SYNC_HIGH_MIN_CYC = (DSW_SYNC_HIGH_MIN_NS * DSW_CLK_MHZ + 999) / 1000;

  // ==========================================================
  // types
  typedef struct packed {
    logic [1:0] mode;
    logic [11:0] code;
    logic [1:0] spare;
  } dsw_word_type;

  typedef struct packed {
    logic sclk;
    logic frame_n;
    logic data;
  } dsw_pins_type;

  typedef struct packed {
    logic [1:0] mode;
    logic [11:0] code;
    logic update;
    logic overrun;
  } dsw_dac_type;

  typedef enum logic [1:0] {
    DSW_IDLE = 2'b00,
    DSW_SHIFT = 2'b01,
    DSW_DONE = 2'b10
  } dsw_state_type;

  typedef struct packed {
    dsw_pins_type s1;
    dsw_pins_type s2;
    dsw_pins_type s3;
    dsw_state_type fsm;
    logic [15:0] shift;
    logic [4:0] cnt;
    logic pend;
    dsw_word_type pend_word;
    dsw_dac_type dac;
    logic frame_active;
  } dsw_top_state_type;

  localparam dsw_pins_type DSW_PINS_RST = 3'h6;
  localparam dsw_dac_type DSW_DAC_RST = '{mode: DSW_MODE_RST, code: DSW_CODE_RST,
                                           update: 1'b0, overrun: 1'b0};
  localparam dsw_top_state_type DSW_TOP_RST = '{s1: DSW_PINS_RST, s2: DSW_PINS_RST,
                                                s3: DSW_PINS_RST, fsm: DSW_IDLE,
                                                shift: 16'h0000, cnt: DSW_CNT_RST,
                                                pend: 1'b0, pend_word: 16'h0000,
                                                dac: DSW_DAC_RST, frame_active: 1'b0};

endpackage

// ==== rtl/dsw_fifo.sv ====
`timescale 1ns/1ps
module dsw_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  import dsw_pkg::*;

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0] wr;
    logic [AW:0] rd;
  } dsw_fifo_state_type;

  dsw_fifo_state_type q;
  dsw_fifo_state_type d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic full;
  logic empty;
  logic push;
  logic pop;

  // ==========================================================
  // flags; depth must be a power of two for the wrap bit to work
  assign full = (q.wr[AW] != q.rd[AW]) && (q.wr[AW-1:0] == q.rd[AW-1:0]);
  assign empty = (q.wr == q.rd);
  assign in_ready_out = ~full;
  assign out_valid_out = ~empty;
  assign out_data_out = mem[q.rd[AW-1:0]];
  assign push = in_valid_in & ~full;
  assign pop = out_ready_in & ~empty;

  // pointer advance
  always_comb begin
    d = q;
    if (push) begin
      d.wr = q.wr + 1'b1;
    end
    if (pop) begin
      d.rd = q.rd + 1'b1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // storage needs no reset; empty flag hides stale words
  always_ff @(posedge clock_in) begin
    if (push) begin
      mem[q.wr[AW-1:0]] <= in_data_in;
    end
  end

endmodule

// ==== dv/dsw_port_sva.sv ====
`timescale 1ns/1ps
// ==========
// port checks
module dsw_sva (
  input wire logic clock_in,
  input wire logic nrst_in,
  input dsw_pkg::dsw_pins_type pins_in,
  input wire logic dac_ready_in,
  input dsw_pkg::dsw_dac_type dac_out,
  input wire logic frame_active_out
);
  import dsw_pkg::*;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!nrst_in);
  // a frame opens only behind a low select
  property p_start;
    $rose(frame_active_out) |-> !$past(pins_in.frame_n, 2);
  endproperty
  a_start: assert property (p_start) else $error("frame began without select");
  // a raised select ends any frame
  property p_abort;
    pins_in.frame_n [*6] |=> !frame_active_out;
  endproperty
  a_abort: assert property (p_abort) else $error("frame kept after select rose");
  // a word is applied only when the converter took it
  property p_pop;
    dac_out.update |-> $past(dac_ready_in);
  endproperty
  a_pop: assert property (p_pop) else $error("update without ready");
  // mode and code move only with an update
  property p_hold;
    $changed({dac_out.mode, dac_out.code}) |-> dac_out.update;
  endproperty
  a_hold: assert property (p_hold) else $error("outputs moved silently");
  // lost words must stay visible until reset
  property p_sticky;
    dac_out.overrun |=> dac_out.overrun;
  endproperty
  a_sticky: assert property (p_sticky) else $error("overrun flag dropped");
  // shifting only while select was low three samples back, sync depth included
  property p_window;
    frame_active_out |-> !$past(pins_in.frame_n, 3);
  endproperty
  a_window: assert property (p_window) else $error("shifting with select high");
endmodule

// ==== dv/dsw_host.sv ====
`timescale 1ns/1ps
// ==========
// serial master model
module dsw_host (
  input wire logic clock_in,
  output dsw_pkg::dsw_pins_type pins_out
);
  import dsw_pkg::*;
  initial pins_out = DSW_PINS_RST;
  // msb first; clock parked high outside frames
  task automatic send(input logic [15:0] w, input int n);
    pins_out.frame_n <= 1'b0;
    repeat (16) @(posedge clock_in);
    for (int i = 15; i > 15 - n; i--) begin
      pins_out.data <= w[i];
      repeat (16) @(posedge clock_in);
      pins_out.sclk <= 1'b0;
      repeat (16) @(posedge clock_in);
      pins_out.sclk <= 1'b1;
    end
    // stale data shows its inverse
    pins_out.data <= ~pins_out.data;
    pins_out.frame_n <= 1'b1;
    repeat (16) @(posedge clock_in);
  endtask
endmodule

// ==== dv/dsw_port_test.sv ====
`timescale 1ns/1ps
module dsw_port_test;
  import dsw_pkg::*;
  logic clock_in = 1'b0;
  logic nrst_in = 1'b0;
  logic dac_ready_in = 1'b1;
  dsw_pins_type pins;
  dsw_dac_type dac_out;
  logic frame_active_out;
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;
  int updates = 0;
  always #2.5 clock_in = ~clock_in;
  dsw_host dsw_host_inst (.clock_in(clock_in), .pins_out(pins));
  dsw_port dsw_port_inst (.clock_in(clock_in), .nrst_in(nrst_in), .pins_in(pins),
    .dac_ready_in(dac_ready_in), .dac_out(dac_out), .frame_active_out(frame_active_out));
  // count updates; cut a hang short
  always @(posedge clock_in) begin
    cycles++;
    if (dac_out.update === 1'b1) updates++;
    if (cycles == 20000) begin
      bad_count++;
      conclude();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("mismatches %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // one full word in each mode
  task automatic t_modes();
    logic [15:0] w;
    int u;
    for (int m = 0; m < 4; m++) begin
      w = {m[1:0], 12'hA5C ^ {4{m[2:0]}}, m[1:0]};
      u = updates;
      dsw_host_inst.send(w, 16);
      chk({2'h0, dac_out.mode, dac_out.code}, {2'h0, w[15:2]});
      chk(16'(updates - u), 16'h0001);
    end
  endtask
  // fifteen bits then select high: nothing moves
  task automatic t_abort();
    int u;
    u = updates;
    dsw_host_inst.send(16'h7FFF, 15);
    chk({2'h0, dac_out.mode, dac_out.code}, 16'h3C87);
    chk(16'(updates - u), 16'h0000);
    chk({15'h0000, frame_active_out}, 16'h0000);
  endtask
  // stall converter, overflow buffer, then drain
  task automatic t_fill();
    int u;
    dac_ready_in <= 1'b0;
    for (int i = 0; i < 10; i++) dsw_host_inst.send({2'h0, 12'(i), 2'h0}, 16);
    chk({15'h0000, dac_out.overrun}, 16'h0001);
    u = updates;
    dac_ready_in <= 1'b1;
    repeat (40) @(posedge clock_in);
    chk(16'(updates - u), 16'h0009);
    chk({4'h0, dac_out.code}, 16'h0008);
  endtask
  initial begin
    repeat (8) @(posedge clock_in);
    nrst_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    t_modes();
    t_abort();
    t_fill();
    conclude();
  end
endmodule
bind dsw_port dsw_sva dsw_sva_inst (.clock_in(clock_in), .nrst_in(nrst_in), .pins_in(pins_in),
  .dac_ready_in(dac_ready_in), .dac_out(dac_out), .frame_active_out(frame_active_out));
